// ==== shared/watchdog_pkg.sv ====
package watchdog_pkg;
  // write side bookkeeping of the slave
  typedef struct packed {
    logic aw_got; // write address held
    logic w_got; // write data held
    logic [11:0] awaddr; // held address
    logic [31:0] wdata; // held data
    logic [3:0] wstrb; // held strobes
  } wr_hold_t;
  // slave response states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_resp = 2'b01
  } resp_state_t;
endpackage

// ==== shared/watchdog_regs.svh ====
// Behaviour
// - five-bit prescale field in bits 5 to 1
// - code zero divides by 32, 1 ms
// - code 10010 divides by 2^23, 256 s
// - reserved codes act as minimum interval
// - prescale field resets to code 01011
// - software enable acts only when config is 01
// - counts cycles of the 31 kHz oscillator
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH
// register byte addresses
`define WDG_CTRL_ZERO_ADDR 12'h80c
`define WDG_CLEAR_ADDR 12'h810
`define WDG_STATUS_ADDR 12'h814
// field positions in the control register
`define WDG_EN_BIT 0
`define WDG_PS_LSB 1
`define WDG_PS_MSB 5
// reset values and limits
`define WDG_PS_RESET 5'h0b
`define WDG_PS_MAX 5'h12
`define WDG_EN_RESET 1'b0
// base divide ratio as a power of two (1:32)
`define WDG_BASE_SHIFT 5
// config encoding that hands control to software
`define WDG_CFG_SOFT 2'h1
// clear register key
`define WDG_CLEAR_KEY 8'h5a
`endif

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0; // system clock
  logic aresetn = 1'b0; // reset, low
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic osc = 1'b0; // slow oscillator
  logic [1:0] cfg = 2'h0; // enable config
  wire logic awready, wready, bvalid, arready, rvalid, wdg_to;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int fails = 0;
  int samples_checked = 0;
  int ticks = 0; // oscillator rising edges
  int div = 0; // oscillator divider
  ////////////////////////////////////////////////////////////////
  // clock, and an oscillator of 8 clocks period so counts stay short
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    div <= div + 1;
    if (div % 4 == 3) osc <= ~osc;
  end
  always @(posedge osc) ticks = ticks + 1;
  watchdog_prescale_control watchdog_prescale_control_i (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .watchdog_enable_config(cfg),
    .low_freq_internal_osc(osc), .watchdog_timeout(wdg_to));
  ////////////////////////////////////////////////////////////////
  // one compare for every kind of result
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bus write: ready, valid and the answer are read at the falling edge, where they already stand
  // as the next rising edge takes them; each half drops after the rising edge that takes it
  // no cycle count is assumed, only the hang guard ends a wait
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // bus read, same manner
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////
  // reset value, field layout, unmapped place
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(12'h80c, d, r);
    chk("ctl_reset", 32'h16, d);
    chk("rd_resp", 32'h0, {30'h0, r});
    axw(12'h80c, 32'hffffffff, r);
    axr(12'h80c, d, r);
    chk("ctl_fields", 32'h3f, d);
    axw(12'h80c, 32'h25, r);
    axr(12'h80c, d, r);
    chk("ctl_longest", 32'h25, d);
    axr(12'h900, d, r);
    chk("unmapped_rresp", 32'h2, {30'h0, r});
    chk("unmapped_rdata", 32'h0, d);
    axw(12'h900, 32'h1, r);
    chk("unmapped_bresp", 32'h2, {30'h0, r});
    axw(12'h814, 32'h1, r);
    chk("status_bresp", 32'h2, {30'h0, r});
    $display("test regs done");
  endtask
  // set config and control, restart, then count ticks until the pulse
  task automatic run_to(input logic [1:0] c, input logic [5:0] ctl, input int lo, input int hi,
                        input logic fire);
    logic [1:0] r;
    int t0;
    logic seen;
    cfg <= c;
    repeat (4) @(posedge aclk);
    axw(12'h80c, {26'h0, ctl}, r);
    axw(12'h810, 32'h5a, r);
    t0 = ticks;
    seen = 1'b0;
    while (!seen && ticks - t0 <= hi) begin
      @(posedge aclk);
      seen = (wdg_to === 1'b1);
    end
    chk("timeout_fired", {31'h0, fire}, {31'h0, seen});
    if (fire) chk("timeout_ticks", 32'h1, {31'h0, (ticks - t0 >= lo) && (ticks - t0 <= hi)});
    $display("test run cfg %b ctl %h done", c, ctl);
  endtask
  task automatic t_times;
    logic [31:0] d;
    logic [1:0] r;
    run_to(2'h1, 6'h01, 30, 34, 1'b1);
    run_to(2'h1, 6'h03, 62, 66, 1'b1);
    run_to(2'h1, 6'h27, 30, 34, 1'b1);
    run_to(2'h1, 6'h3f, 30, 34, 1'b1);
    run_to(2'h1, 6'h00, 0, 80, 1'b0);
    run_to(2'h0, 6'h01, 0, 80, 1'b0);
    run_to(2'h2, 6'h00, 30, 34, 1'b1);
    run_to(2'h3, 6'h00, 30, 34, 1'b1);
    axr(12'h814, d, r);
    chk("status_flags", 32'h3, d);
    $display("test status done");
  endtask
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard, well beyond the run length
  initial begin
    #300us;
    fails++;
    final_report;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_times;
    final_report;
  end
endmodule // tb_top
`default_nettype wire

// ==== verilog/watchdog_prescale_control.sv ====
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_regs.svh"
module watchdog_prescale_control
  import watchdog_pkg::*;
#(
  parameter int PS_W = 5, // prescale field width
  parameter int CNT_W = 29 // osc tick counter width
) (
  input wire logic aclk, // 100 mhz clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [11:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [11:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [1:0] watchdog_enable_config, // config fuse setting
  input wire logic low_freq_internal_osc, // 31 khz oscillator pin
  output logic watchdog_timeout // one-cycle timeout reset pulse
);

  // refuse parameters that the field layout and the longest interval cannot serve
  initial begin
    if (PS_W != 5 || CNT_W < 29) begin
      $error("watchdog parameters out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator synchroniser and edge detect
  logic osc_s1_ff, osc_s2_ff, osc_s3_ff; // sync chain and edge history
  logic nxt_osc_s1, nxt_osc_s2, nxt_osc_s3; // next sync chain values
  logic [1:0] cfg_s1_ff, nxt_cfg_s1; // first config stage
  logic cfg0_ff, cfg1_ff, nxt_cfg0, nxt_cfg1; // synced config bits
  logic osc_tick; // one cycle per oscillator rising edge
  // next values of both sync chains
  always_comb begin
    nxt_osc_s1 = low_freq_internal_osc;
    nxt_osc_s2 = osc_s1_ff;
    nxt_osc_s3 = osc_s2_ff;
    nxt_cfg_s1 = watchdog_enable_config;
    nxt_cfg0 = cfg_s1_ff[0];
    nxt_cfg1 = cfg_s1_ff[1];
  end
  // sync flops carry no reset, so they settle while reset is held
  always_ff @(posedge aclk) begin
    osc_s1_ff <= nxt_osc_s1;
    osc_s2_ff <= nxt_osc_s2;
    osc_s3_ff <= nxt_osc_s3;
    cfg_s1_ff <= nxt_cfg_s1;
    cfg0_ff <= nxt_cfg0;
    cfg1_ff <= nxt_cfg1;
  end
  // rising edge of the synced pin, read only past the second flop
  assign osc_tick = osc_s2_ff & ~osc_s3_ff;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  wr_hold_t wr_ff, nxt_wr;
  resp_state_t bst_ff, nxt_bst;
  logic [1:0] bresp_ff, nxt_bresp;
  logic [PS_W-1:0] ps_ff, nxt_ps; // prescale select
  logic swen_ff, nxt_swen; // software enable
  logic wr_fire; // both halves held, commit now
  logic clear_hit; // watchdog clear written
  // ready while the half is not yet held and no response is pending
  assign awready = ~wr_ff.aw_got & (bst_ff == st_idle);
  assign wready = ~wr_ff.w_got & (bst_ff == st_idle);
  assign wr_fire = wr_ff.aw_got & wr_ff.w_got & (bst_ff == st_idle);
  // write channel next state and register update
  always_comb begin
    nxt_wr = wr_ff;
    nxt_bst = bst_ff;
    nxt_bresp = bresp_ff;
    nxt_ps = ps_ff;
    nxt_swen = swen_ff;
    clear_hit = 1'b0;
    // capture address and data in either order
    if (awvalid && awready) begin
      nxt_wr.aw_got = 1'b1;
      nxt_wr.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_wr.w_got = 1'b1;
      nxt_wr.wdata = wdata;
      nxt_wr.wstrb = wstrb;
    end
    if (wr_fire) begin
      nxt_wr.aw_got = 1'b0;
      nxt_wr.w_got = 1'b0;
      nxt_bst = st_resp;
      nxt_bresp = 2'b00;
      unique case ({wr_ff.awaddr[11:2], 2'b00})
        `WDG_CTRL_ZERO_ADDR: begin
          if (wr_ff.wstrb[0]) begin
            nxt_ps = wr_ff.wdata[`WDG_PS_MSB:`WDG_PS_LSB];
            nxt_swen = wr_ff.wdata[`WDG_EN_BIT];
          end
        end
        `WDG_CLEAR_ADDR: begin
          // key write restarts the count
          clear_hit = wr_ff.wstrb[0] && (wr_ff.wdata[7:0] == `WDG_CLEAR_KEY);
        end
        `WDG_STATUS_ADDR: begin
          nxt_bresp = 2'b10; // read-only
        end
        default: begin
          nxt_bresp = 2'b10; // unmapped
        end
      endcase
    end
    if (bst_ff == st_resp && bready) begin
      nxt_bst = st_idle;
    end
  end
  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ff <= '0;
      bst_ff <= st_idle;
      bresp_ff <= 2'b00;
      ps_ff <= `WDG_PS_RESET;
      swen_ff <= `WDG_EN_RESET;
    end else begin
      wr_ff <= nxt_wr;
      bst_ff <= nxt_bst;
      bresp_ff <= nxt_bresp;
      ps_ff <= nxt_ps;
      swen_ff <= nxt_swen;
    end
  end
  // response stands until bready
  assign bvalid = (bst_ff == st_resp);
  assign bresp = bresp_ff;

  ////////////////////////////////////////////////////////////////////////
  // watchdog counter
  logic running; // watchdog is counting
  logic [4:0] eff_shift; // effective power-of-two ratio
  logic [CNT_W-1:0] cnt_ff, nxt_cnt, limit; // tick count and its end
  logic tmo_ff, nxt_tmo; // timeout pulse
  logic flag_ff, nxt_flag; // sticky timeout seen
  // run gate, interval limit, count and timeout decision
  always_comb begin
    // config 01 gives software the switch, 1x forces on, 00 off
    if (cfg1_ff) begin
      running = 1'b1;
    end else if (cfg0_ff) begin
      running = swen_ff;
    end else begin
      running = 1'b0;
    end
    // reserved codes fall back to the shortest interval
    if (ps_ff > `WDG_PS_MAX) begin
      eff_shift = 5'(`WDG_BASE_SHIFT);
    end else begin
      eff_shift = ps_ff + 5'(`WDG_BASE_SHIFT);
    end
    limit = CNT_W'(1) << eff_shift;
    nxt_cnt = cnt_ff;
    nxt_tmo = 1'b0;
    nxt_flag = flag_ff;
    if (!running || clear_hit) begin
      nxt_cnt = '0;
    end else if (osc_tick) begin
      if (cnt_ff + CNT_W'(1) >= limit) begin
        nxt_cnt = '0;
        nxt_tmo = 1'b1;
        nxt_flag = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
  end
  // counter registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      tmo_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tmo_ff <= nxt_tmo;
      flag_ff <= nxt_flag;
    end
  end
  // pulse comes from a flop, one cycle wide
  assign watchdog_timeout = tmo_ff;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  logic rv_ff, nxt_rv; // read answer pending
  logic [31:0] rd_ff, nxt_rd; // read data
  logic [1:0] rr_ff, nxt_rr; // read response
  assign arready = ~rv_ff;
  // read channel next state and register mux
  always_comb begin
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (arvalid && arready) begin
      nxt_rv = 1'b1;
      nxt_rr = 2'b00;
      unique case ({araddr[11:2], 2'b00})
        `WDG_CTRL_ZERO_ADDR: nxt_rd = {26'h0, ps_ff, swen_ff};
        `WDG_CLEAR_ADDR: nxt_rd = 32'h0;
        `WDG_STATUS_ADDR: nxt_rd = {30'h0, flag_ff, running};
        default: begin
          nxt_rd = 32'h0;
          nxt_rr = 2'b10;
        end
      endcase
    end else if (rv_ff && rready) begin
      nxt_rv = 1'b0;
    end
  end
  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_ff <= 1'b0;
      rd_ff <= 32'h0;
      rr_ff <= 2'b00;
    end else begin
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
    end
  end
  // read answer stands in flops until rready
  assign rvalid = rv_ff;
  assign rdata = rd_ff;
  assign rresp = rr_ff;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  a_ps_reset_val: assert property (@(posedge aclk) !aresetn |=> ps_ff == `WDG_PS_RESET)
    else $error("prescale reset value wrong");
  a_reserved_min: assert property (@(posedge aclk) disable iff (!aresetn)
    ps_ff > `WDG_PS_MAX |-> limit == (CNT_W'(1) << `WDG_BASE_SHIFT))
    else $error("reserved code not minimum");
  a_code_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ps_ff == 5'h00 |-> limit == CNT_W'(32))
    else $error("code zero not 1:32");
  a_code_max: assert property (@(posedge aclk) disable iff (!aresetn)
    ps_ff == 5'h12 |-> limit == CNT_W'(8388608))
    else $error("code 10010 not 2^23");
  a_soft_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg1_ff && !cfg0_ff) |-> !running)
    else $error("watchdog ran while disabled");
  a_soft_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg1_ff && cfg0_ff) |-> running == swen_ff)
    else $error("software enable ignored");
  a_count_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !running |=> cnt_ff == '0)
    else $error("count moved while stopped");
  a_tick_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (cnt_ff != $past(cnt_ff) && cnt_ff != '0) |-> $past(osc_tick))
    else $error("count moved without oscillator tick");
  a_limit_exact: assert property (@(posedge aclk) disable iff (!aresetn)
    (running && osc_tick && !clear_hit && cnt_ff == limit - CNT_W'(1)) |=> watchdog_timeout)
    else $error("interval reached without timeout");
  a_timeout_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    watchdog_timeout |-> $past(running) && $past(osc_tick))
    else $error("timeout without running tick");
  a_pulse_single: assert property (@(posedge aclk) disable iff (!aresetn)
    watchdog_timeout |=> !watchdog_timeout)
    else $error("timeout pulse longer than one cycle");
  a_flag_record: assert property (@(posedge aclk) disable iff (!aresetn)
    watchdog_timeout |-> flag_ff)
    else $error("timeout not recorded in status");
  a_clear_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    clear_hit |=> cnt_ff == '0)
    else $error("clear did not restart count");
  a_field_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_ff.awaddr[11:2] == 10'h203 && wr_ff.wstrb[0])
    |=> ps_ff == $past(wr_ff.wdata[5:1]))
    else $error("prescale field not written");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  // covers for the main scenarios
  c_timeout: cover property (@(posedge aclk) watchdog_timeout);
  c_write: cover property (@(posedge aclk) bvalid && bready);
  c_read: cover property (@(posedge aclk) rvalid && rready);
  c_clear: cover property (@(posedge aclk) clear_hit && running);
  c_reserved: cover property (@(posedge aclk) ps_ff > `WDG_PS_MAX && watchdog_timeout);

endmodule // watchdog_prescale_control
`default_nettype wire
